// [irq_ctrl_regs.svh]
`ifndef IRQ_CTRL_REGS_SVH
`define IRQ_CTRL_REGS_SVH

// ************************
// Register word offsets (byte addresses on the register port)
// ************************
`define OFS_CORE_LATCHED 8'h00
`define OFS_CORE_ENABLE 8'h04
`define OFS_CORE_ACTIVE 8'h08
`define OFS_PERIPH_ENABLE 8'h0c
`define OFS_PERIPH_STATUS 8'h10
`define OFS_PERIPH_WAKE 8'h14
`define OFS_ASSIGN0 8'h18
`define OFS_ASSIGN1 8'h1c
`define OFS_ASSIGN2 8'h20
`define OFS_ASSIGN3 8'h24
`define OFS_GLOBAL_CTRL 8'h28

// ************************
// Field positions
// ************************
`define GP_LO_BIT 7
`define GP_HI_BIT 15
`define GLOBAL_EN_BIT 0

// ************************
// Reset values
// ************************
`define CORE_ENABLE_RST 9'h000
`define PERIPH_ENABLE_RST 32'h00000000
`define PERIPH_WAKE_RST 32'h00000000
// One nibble per peripheral ID, ID 0 in the lowest nibble of word 0
`define ASSIGN0_RST 32'h99988777
`define ASSIGN1_RST 32'hbaaaaa99
`define ASSIGN2_RST 32'hcccccbbb
`define ASSIGN3_RST 32'hdddccccc

// ************************
// Timing counts in core clock cycles
// ************************
`define PIN_SYNC_STAGES 2
`define EDGE_DETECT_CYCLES 2

`endif

// [irq_ctrl_pkg.sv]
package irq_ctrl_pkg;

  // ************************
  // Types
  // ************************
  // One-hot states of the service request towards the pipeline
  typedef enum logic [1:0] {
    SVC_IDLE = 2'b01,
    SVC_REQ = 2'b10
  } svc_state_type;

  // Result of a priority search over the nine general-purpose levels
  typedef struct packed {
    logic found; // Some bit was set
    logic [3:0] idx; // Offset of the winner from level seven
  } prio_type;

  // Whole state of the core event stage
  typedef struct packed {
    logic [8:0] latched; // Latched events, levels 7..15
    logic [8:0] enable; // Event enables, levels 7..15
    logic [8:0] active; // Active or nested events, levels 7..15
    logic [8:0] line_q; // First sample of the level lines
    logic [8:0] line_prev; // Second sample, for edge detection
    logic glob_en; // Global general-purpose enable
    svc_state_type svc_state; // Request handshake state
    logic svc_req; // Request to the pipeline
    logic [3:0] svc_level; // Level number being requested
    logic [31:0] periph_enable; // Peripheral enables
    logic [31:0] periph_wake; // Peripheral wake enables
    logic [127:0] assign_map; // Level nibble per peripheral ID
    logic [31:0] rdata; // Read data of the register port
  } core_state_type;

  // Whole state of the peripheral routing stage
  typedef struct packed {
    logic [31:0] sync1; // First synchroniser stage
    logic [31:0] sync2; // Second synchroniser stage
    logic [31:0] sync3; // Delayed copy for edge detection
    logic [8:0] line; // Level lines towards the core stage
    logic [8:0] pend; // Edge that met an acknowledge
    logic [8:0] ack_q; // Previous acknowledge vector
    logic wake; // Wake request
  } route_state_type;

  // ************************
  // Functions
  // ************************
  // Lowest set bit wins, as a lower level has the higher priority
  function automatic prio_type lowest_gp(input logic [8:0] vec);
    prio_type res;
    res = '0;
    for (int i = 8; i >= 0; i--) begin
      if (vec[i]) begin
        res.found = 1'b1;
        res.idx = 4'(i);
      end
    end
    return res;
  endfunction

  // Place the nine level bits at their positions in a 32-bit word
  function automatic logic [31:0] widen_gp(input logic [8:0] vec);
    return {16'h0000, vec, 7'h00};
  endfunction

  // Routed level number of one peripheral ID
  function automatic logic [3:0] level_of(input logic [127:0] map, input int id);
    return map[id*4 +: 4];
  endfunction

endpackage : irq_ctrl_pkg

// [irq_routing_stage.sv]
`timescale 1ns/1ps
`default_nettype none
`include "irq_ctrl_regs.svh"

module irq_routing_stage import irq_ctrl_pkg::*; (
  input wire logic sys_clk, // Core clock
  input wire logic rst, // Synchronous reset, active high
  input wire logic [31:0] periph_irq, // Raw peripheral lines, asynchronous
  input wire logic [31:0] periph_enable, // Peripheral enables
  input wire logic [31:0] periph_wake, // Peripheral wake enables
  input wire logic [127:0] assign_map, // Level nibble per ID
  input wire logic [8:0] ack, // Active events of the core stage
  input wire logic core_idle, // Core is idled
  output logic [31:0] status, // Synchronised peripheral lines
  output logic [8:0] gp_line, // Level lines to the core stage
  output logic wake_req // Wake request to power management
);

  // ************************
  // State
  // ************************
  route_state_type st_reg; // Registered state
  route_state_type st_next; // Next state

  // ************************
  // Next-state logic
  // ************************
  // Sources are synchronised, edge detected per ID, then merged
  always_comb begin
    logic [31:0] src_edge;
    logic [8:0] lvl_edge;
    logic [8:0] ack_rise;
    logic [8:0] collide;
    logic [3:0] lvl;
    src_edge = '0;
    lvl_edge = '0;
    ack_rise = '0;
    collide = '0;
    lvl = '0;
    st_next = st_reg;
    st_next.sync1 = periph_irq;
    st_next.sync2 = st_reg.sync1;
    st_next.sync3 = st_reg.sync2;
    // A masked source never reaches a level
    src_edge = st_reg.sync2 & ~st_reg.sync3 & periph_enable; // R15
    // Each ID follows its programmed level, shared IDs simply OR
    for (int i = 0; i < 32; i++) begin
      lvl = level_of(assign_map, i); // R2
      if (src_edge[i] && lvl >= 4'(`GP_LO_BIT)) begin
        lvl_edge[4'(lvl - 4'(`GP_LO_BIT))] = 1'b1; // R1 R23
      end
    end
    // The active bits of the core stage act as acknowledge
    ack_rise = ack & ~st_reg.ack_q; // R19
    st_next.ack_q = ack;
    // Line stays up until acknowledged; an edge meeting the acknowledge
    // drops the line for one cycle so the core sees a fresh edge
    collide = ack_rise & st_reg.line & lvl_edge; // R18
    st_next.pend = collide;
    st_next.line = st_reg.pend | (st_reg.line & ~ack_rise) | (lvl_edge & ~collide); // R18
    // Wake does not depend on the peripheral enable
    st_next.wake = core_idle & (|(st_reg.sync2 & periph_wake)); // R17
    if (rst) begin
      st_next = '0;
    end
  end

  // ************************
  // State register
  // ************************
  always_ff @(posedge sys_clk) begin
    st_reg <= st_next;
  end

  assign status = st_reg.sync2; // R16
  assign gp_line = st_reg.line;
  assign wake_req = st_reg.wake;

endmodule // irq_routing_stage

`default_nettype wire

// [two_stage_interrupt_controller.sv]
// Function
// R1: Route every peripheral source to a level
// R2: Software assignment registers override default routing
// R3: Default routing of IDs 0-31 to levels 7-13
// R4: Core stage holds latched, enable, active registers
// R5: Rising edge sets latched bit in two cycles
// R6: Latched bit clears when active bit sets
// R7: Latched writes act only where enable clear
// R8: Enable one services event, zero blocks it
// R9: Masked events are still latched
// R10: Enable register accessible only in supervisor mode
// R11: Global on and off instructions gate levels
// R12: Active bit set per serviced or nested event
// R13: Active register hardware-updated, supervisor-only read
// R14: Peripheral enable, status, wake registers, 32 bits
// R15: Peripheral enable zero masks that source
// R16: Status bit mirrors the asserting peripheral
// R17: Wake-enabled source wakes an idled core
// R18: Simultaneous shared-level pulses are tolerated
// R19: Active bits serve as routing acknowledge
// R20: Next edge is queued once active
// R21: Active no sooner than three cycles
// R22: Nine levels, lower number wins
// R23: Level input is OR of enabled sources
//
// Strobed register access and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "irq_ctrl_regs.svh"

module two_stage_interrupt_controller import irq_ctrl_pkg::*; (
  input wire logic sys_clk, // Core clock, 40 MHz
  input wire logic rst, // Synchronous reset, active high
  input wire logic [7:0] reg_addr, // Register byte address
  input wire logic [31:0] reg_wdata, // Register write data
  input wire logic reg_wr, // Write strobe
  input wire logic reg_rd, // Read strobe
  output logic [31:0] reg_rdata, // Read data, cycle after the strobe
  input wire logic supervisor_mode, // Processor runs in supervisor mode
  input wire logic [31:0] periph_irq, // Peripheral interrupt lines
  input wire logic global_irq_on, // Global enable instruction pulse
  input wire logic global_irq_off, // Global disable instruction pulse
  input wire logic core_idle, // Core is idled
  input wire logic evt_accept, // Pipeline takes the requested level
  input wire logic evt_return, // Return from an event handler
  input wire logic [3:0] evt_return_level, // Level that returns
  output logic svc_req, // Service request to the pipeline
  output logic [3:0] svc_level, // Level number of the request
  output logic [31:0] active_events, // Active events, to the pipeline
  output logic [31:0] periph_status, // Peripheral status mirror
  output logic wake_req // Wake request to power management
);

  // ************************
  // State and wires
  // ************************
  core_state_type st_reg; // Registered state
  core_state_type st_next; // Next state
  logic [8:0] gp_line; // Level lines from the routing stage
  logic [31:0] route_status; // Synchronised peripheral lines

  // ************************
  // Routing stage
  // ************************
  irq_routing_stage routing (
    .sys_clk(sys_clk),
    .rst(rst),
    .periph_irq(periph_irq),
    .periph_enable(st_reg.periph_enable),
    .periph_wake(st_reg.periph_wake),
    .assign_map(st_reg.assign_map),
    .ack(st_reg.active), // R19
    .core_idle(core_idle),
    .status(route_status),
    .gp_line(gp_line),
    .wake_req(wake_req)
  );

  // ************************
  // Next-state logic of the core stage
  // ************************
  // Order inside this process sets precedence: software writes first,
  // then handler return and pipeline accept, and hardware edges last so that
  // a new edge is never lost to a clear in the same cycle.
  always_comb begin
    logic [8:0] edge_det;
    logic [8:0] wgp;
    logic [8:0] ready;
    logic [3:0] acc_idx;
    logic [3:0] ret_idx;
    logic take;
    prio_type pend;
    prio_type top;
    edge_det = '0;
    wgp = '0;
    ready = '0;
    acc_idx = '0;
    ret_idx = '0;
    take = 1'b0;
    pend = '0;
    top = '0;
    st_next = st_reg;

    // Two samples of the level lines give the edge
    st_next.line_q = gp_line;
    st_next.line_prev = st_reg.line_q;
    edge_det = st_reg.line_q & ~st_reg.line_prev; // R5
    wgp = reg_wdata[`GP_HI_BIT:`GP_LO_BIT];

    // Register writes
    if (reg_wr) begin
      unique case (reg_addr)
        `OFS_CORE_LATCHED: begin
          // Bits whose event is enabled are owned by hardware
          st_next.latched = (st_reg.latched & st_reg.enable) | (wgp & ~st_reg.enable); // R7
        end
        `OFS_CORE_ENABLE: begin
          if (supervisor_mode) begin
            st_next.enable = wgp; // R10
          end
        end
        `OFS_PERIPH_ENABLE: begin
          st_next.periph_enable = reg_wdata; // R14
        end
        `OFS_PERIPH_WAKE: begin
          st_next.periph_wake = reg_wdata; // R14
        end
        `OFS_ASSIGN0: begin
          st_next.assign_map[31:0] = reg_wdata; // R2
        end
        `OFS_ASSIGN1: begin
          st_next.assign_map[63:32] = reg_wdata; // R2
        end
        `OFS_ASSIGN2: begin
          st_next.assign_map[95:64] = reg_wdata; // R2
        end
        `OFS_ASSIGN3: begin
          st_next.assign_map[127:96] = reg_wdata; // R2
        end
        default: begin
          // Active, status and unmapped words ignore writes
          st_next.enable = st_next.enable; // R13
        end
      endcase
    end

    // Global on and off; off wins if both arrive together
    if (global_irq_off) begin
      st_next.glob_en = 1'b0; // R11
    end else if (global_irq_on) begin
      st_next.glob_en = 1'b1; // R11
    end

    // Return from a handler retires its nesting level
    ret_idx = 4'(evt_return_level - 4'(`GP_LO_BIT));
    if (evt_return && evt_return_level >= 4'(`GP_LO_BIT)) begin
      st_next.active[ret_idx] = 1'b0; // R12
    end

    // Entry into the pipeline marks active and consumes the latch
    acc_idx = 4'(st_reg.svc_level - 4'(`GP_LO_BIT));
    if (evt_accept && st_reg.svc_req) begin
      st_next.active[acc_idx] = 1'b1; // R12
      st_next.latched[acc_idx] = 1'b0; // R6
    end

    // Edges latch regardless of enables, and a fresh edge after the
    // accept is queued again
    st_next.latched = st_next.latched | edge_det; // R9 R20

    // Priority search: only enabled, globally allowed events compete,
    // and only if they outrank everything already nested
    ready = st_reg.latched & st_reg.enable & {9{st_reg.glob_en}}; // R8 R11
    pend = lowest_gp(ready); // R22
    top = lowest_gp(st_reg.active); // R22
    take = pend.found && (!top.found || pend.idx < top.idx);

    // Service request handshake
    unique case (st_reg.svc_state)
      SVC_IDLE: begin
        if (take) begin
          // Request comes one cycle after the latch, so the earliest
          // active bit is at least three cycles after the line edge
          st_next.svc_state = SVC_REQ; // R21
          st_next.svc_req = 1'b1;
          st_next.svc_level = 4'(pend.idx + 4'(`GP_LO_BIT));
        end
      end
      SVC_REQ: begin
        if (evt_accept) begin
          st_next.svc_state = SVC_IDLE;
          st_next.svc_req = 1'b0;
        end else if (take) begin
          // A lower level may overtake the request still waiting
          st_next.svc_level = 4'(pend.idx + 4'(`GP_LO_BIT)); // R22
        end else begin
          // The waiting event got masked away
          st_next.svc_state = SVC_IDLE;
          st_next.svc_req = 1'b0;
        end
      end
    endcase

    // Register reads; read data stand for one cycle only
    st_next.rdata = 32'h00000000;
    if (reg_rd) begin
      unique case (reg_addr)
        `OFS_CORE_LATCHED: begin
          st_next.rdata = widen_gp(st_reg.latched); // R4
        end
        `OFS_CORE_ENABLE: begin
          if (supervisor_mode) begin
            st_next.rdata = widen_gp(st_reg.enable); // R10
          end
        end
        `OFS_CORE_ACTIVE: begin
          if (supervisor_mode) begin
            st_next.rdata = widen_gp(st_reg.active); // R13
          end
        end
        `OFS_PERIPH_ENABLE: begin
          st_next.rdata = st_reg.periph_enable; // R14
        end
        `OFS_PERIPH_STATUS: begin
          st_next.rdata = route_status; // R16
        end
        `OFS_PERIPH_WAKE: begin
          st_next.rdata = st_reg.periph_wake; // R14
        end
        `OFS_ASSIGN0: begin
          st_next.rdata = st_reg.assign_map[31:0];
        end
        `OFS_ASSIGN1: begin
          st_next.rdata = st_reg.assign_map[63:32];
        end
        `OFS_ASSIGN2: begin
          st_next.rdata = st_reg.assign_map[95:64];
        end
        `OFS_ASSIGN3: begin
          st_next.rdata = st_reg.assign_map[127:96];
        end
        `OFS_GLOBAL_CTRL: begin
          st_next.rdata[`GLOBAL_EN_BIT] = st_reg.glob_en;
        end
        default: begin
          // Unmapped words read as zero
          st_next.rdata = 32'h00000000;
        end
      endcase
    end

    // Reset: defaults of the routing map, request state idle, everything else cleared
    if (rst) begin
      st_next = '0;
      st_next.svc_state = SVC_IDLE;
      st_next.enable = `CORE_ENABLE_RST;
      st_next.periph_enable = `PERIPH_ENABLE_RST;
      st_next.periph_wake = `PERIPH_WAKE_RST;
      st_next.assign_map = {`ASSIGN3_RST, `ASSIGN2_RST, `ASSIGN1_RST, `ASSIGN0_RST}; // R3
    end
  end

  // ************************
  // State register
  // ************************
  always_ff @(posedge sys_clk) begin
    st_reg <= st_next;
  end

  // ************************
  // Outputs, all straight from flip-flops
  // ************************
  assign reg_rdata = st_reg.rdata;
  assign svc_req = st_reg.svc_req;
  assign svc_level = st_reg.svc_level;
  assign active_events = widen_gp(st_reg.active); // R12
  assign periph_status = route_status;

endmodule // two_stage_interrupt_controller

`default_nettype wire

// [irq_ctrl_assertions.sv]
`timescale 1ns/1ps
`default_nettype none
`include "irq_ctrl_regs.svh"

// ************************
// Port-level checks of the interrupt controller
// ************************
module irq_ctrl_assertions (
  input wire logic sys_clk, // Core clock
  input wire logic rst, // Synchronous reset
  input wire logic [7:0] reg_addr, // Register address
  input wire logic reg_rd, // Read strobe
  input wire logic [31:0] reg_rdata, // Read data
  input wire logic supervisor_mode, // Supervisor mode
  input wire logic [31:0] periph_irq, // Peripheral lines
  input wire logic global_irq_off, // Global disable pulse
  input wire logic core_idle, // Core idled
  input wire logic evt_accept, // Pipeline take
  input wire logic evt_return, // Handler return
  input wire logic [3:0] evt_return_level, // Returning level
  input wire logic svc_req, // Service request
  input wire logic [3:0] svc_level, // Requested level
  input wire logic [31:0] active_events, // Active events
  input wire logic [31:0] periph_status, // Status mirror
  input wire logic wake_req // Wake request
);
  // One clock domain, so clock and reset are given once
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);

  gp_range_a: assert property (
    active_events[31:16] == 16'h0000 && active_events[6:0] == 7'h00)
    else $error("active bit outside the nine levels");
  level_range_a: assert property (
    svc_req |-> svc_level >= 4'h7 && svc_level <= 4'hf)
    else $error("request level out of range");
  status_sync_a: assert property (
    periph_status == $past(periph_irq, 2))
    else $error("status does not follow the lines");
  accept_sets_a: assert property (
    svc_req && evt_accept |=> active_events[$past(svc_level)])
    else $error("accepted level not active");
  no_spont_a: assert property (
    (active_events & ~$past(active_events)) != 32'h0 |-> $past(svc_req && evt_accept))
    else $error("active bit rose without acceptance");
  ret_clear_a: assert property (
    evt_return |=> !active_events[$past(evt_return_level)])
    else $error("returned level still active");
  // Read data must never leak outside its one-cycle slot
  rdata_idle_a: assert property (
    !$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data without a read");
  priv_read_a: assert property (
    reg_rd && !supervisor_mode && (reg_addr == `OFS_CORE_ENABLE
    || reg_addr == `OFS_CORE_ACTIVE) |=> reg_rdata == 32'h0)
    else $error("privileged register read outside supervisor");
  glob_off_a: assert property (
    global_irq_off |-> ##[1:2] !svc_req)
    else $error("request stands after global disable");
  wake_idle_a: assert property (
    wake_req |-> $past(core_idle))
    else $error("wake request while core not idled");
endmodule // irq_ctrl_assertions
`default_nettype wire

// [pipeline_model.sv]
`timescale 1ns/1ps
`default_nettype none

// ************************
// Pipeline side: takes a request after a chosen stall
// ************************
module pipeline_model (
  input wire logic sys_clk, // Core clock
  input wire logic rst, // Synchronous reset
  input wire logic svc_req, // Request from the controller
  input wire logic [3:0] acc_wait, // Stall cycles before taking
  output logic evt_accept // Take pulse
);
  logic [3:0] wait_reg; // Cycles the request has stood

  // Zero stall takes in the request cycle, like a free core
  assign evt_accept = svc_req && (wait_reg >= acc_wait);

  // Restart the count whenever the request falls or is taken
  always_ff @(posedge sys_clk) begin
    if (rst || !svc_req || evt_accept) begin
      wait_reg <= 4'h0;
    end else begin
      wait_reg <= wait_reg + 4'h1;
    end
  end
endmodule // pipeline_model
`default_nettype wire

// [test_two_stage_interrupt_controller.sv]
`timescale 1ns/1ps
`default_nettype none
`include "irq_ctrl_regs.svh"

module test_two_stage_interrupt_controller;
  // ************************
  // Stimulus and observed signals
  // ************************
  logic sys_clk = 1'b0; // Core clock
  logic rst = 1'b1; // Reset
  logic [7:0] reg_addr = 8'h00; // Register address
  logic [31:0] reg_wdata = 32'h0; // Write data
  logic reg_wr = 1'b0; // Write strobe
  logic reg_rd = 1'b0; // Read strobe
  logic supervisor_mode = 1'b1; // Supervisor mode
  logic [31:0] periph_irq = 32'h0; // Peripheral lines
  logic global_irq_on = 1'b0; // Global enable pulse
  logic global_irq_off = 1'b0; // Global disable pulse
  logic core_idle = 1'b0; // Core idled
  logic evt_return = 1'b0; // Handler return
  logic [3:0] evt_return_level = 4'h7; // Returning level
  logic [3:0] acc_wait = 4'h0; // Pipeline stall
  logic evt_accept, svc_req, wake_req; // Design and model outputs
  logic [3:0] svc_level; // Requested level
  logic [31:0] reg_rdata, active_events, periph_status; // Design outputs
  int errors = 0; // Mismatches
  int n_compared = 0; // Comparisons

  always #12.5 sys_clk = ~sys_clk;

  two_stage_interrupt_controller i_two_stage_interrupt_controller (.sys_clk, .rst,
    .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .supervisor_mode, .periph_irq,
    .global_irq_on, .global_irq_off, .core_idle, .evt_accept, .evt_return,
    .evt_return_level, .svc_req, .svc_level, .active_events, .periph_status, .wake_req);
  pipeline_model i_pipeline_model (.sys_clk, .rst, .svc_req, .acc_wait, .evt_accept);

  // ************************
  // Shared tasks
  // ************************
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  // Read data stands only in the cycle after the strobe
  task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] exp);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 chk(what, exp, reg_rdata);
  endtask
  task automatic glob(input logic on);
    @(posedge sys_clk);
    global_irq_on <= on;
    global_irq_off <= !on;
    @(posedge sys_clk);
    global_irq_on <= 1'b0;
    global_irq_off <= 1'b0;
  endtask
  task automatic ret(input logic [3:0] lv);
    @(posedge sys_clk);
    evt_return <= 1'b1;
    evt_return_level <= lv;
    @(posedge sys_clk);
    evt_return <= 1'b0;
  endtask
  // Short reset, then core, peripheral and global enables on, so each test starts clean
  task automatic restart(input logic [3:0] w);
    @(posedge sys_clk);
    rst <= 1'b1;
    periph_irq <= 32'h0;
    core_idle <= 1'b0;
    acc_wait <= w;
    tick(3);
    rst <= 1'b0;
    wr(`OFS_CORE_ENABLE, 32'h0000ff80);
    wr(`OFS_PERIPH_ENABLE, 32'hffffffff);
    glob(1'b1);
  endtask
  // Raise one source and count edges until its level is active
  task automatic raise(input int id, input int lv, input int exp_n);
    int n = 0;
    @(posedge sys_clk);
    periph_irq[id] <= 1'b1;
    while (active_events[lv] !== 1'b1 && n < 30) begin
      @(posedge sys_clk);
      #1 n++;
    end
    chk("edges to active", exp_n, n);
  endtask
  function automatic logic [3:0] dflt(input int id);
    return id < 3 ? 4'h7 : id < 5 ? 4'h8 : id < 10 ? 4'h9 : id < 15 ? 4'ha :
      id < 19 ? 4'hb : id < 29 ? 4'hc : 4'hd;
  endfunction

  // ************************
  // Scenarios
  // ************************
  task automatic t_reset;
    logic [31:0] w;
    for (int k = 0; k < 4; k++) begin
      for (int i = 0; i < 8; i++) w[i*4 +: 4] = dflt(8*k + i);
      rdc("assign word", `OFS_ASSIGN0 + 8'(4*k), w);
    end
    rdc("core enable", `OFS_CORE_ENABLE, 32'h0);
    rdc("periph enable", `OFS_PERIPH_ENABLE, 32'h0);
    rdc("wake enable", `OFS_PERIPH_WAKE, 32'h0);
    rdc("unmapped", 8'h40, 32'h0);
    rdc("global", `OFS_GLOBAL_CTRL, 32'h0);
    $display("test reset values done");
  endtask
  task automatic t_path;
    restart(4'h0);
    raise(3, 8, 7);
    rdc("status", `OFS_PERIPH_STATUS, 32'h8);
    rdc("latched", `OFS_CORE_LATCHED, 32'h0);
    rdc("active", `OFS_CORE_ACTIVE, 32'h100);
    ret(4'h8);
    rdc("active", `OFS_CORE_ACTIVE, 32'h0);
    $display("test service path done");
  endtask
  task automatic t_mask;
    restart(4'h0);
    wr(`OFS_CORE_ENABLE, 32'h0000fd80);
    periph_irq[5] <= 1'b1;
    tick(12);
    #1 chk("active", 32'h0, active_events);
    rdc("latched", `OFS_CORE_LATCHED, 32'h200);
    wr(`OFS_CORE_LATCHED, 32'h300);
    rdc("latched", `OFS_CORE_LATCHED, 32'h200);
    wr(`OFS_CORE_LATCHED, 32'h0);
    rdc("latched", `OFS_CORE_LATCHED, 32'h0);
    $display("test core mask done");
  endtask
  task automatic t_periph;
    restart(4'h0);
    wr(`OFS_PERIPH_ENABLE, 32'hfffffbff);
    periph_irq[10] <= 1'b1;
    tick(12);
    rdc("latched", `OFS_CORE_LATCHED, 32'h0);
    rdc("status", `OFS_PERIPH_STATUS, 32'h400);
    raise(11, 10, 7);
    wr(`OFS_ASSIGN0, 32'h99988779);
    raise(0, 9, 7);
    $display("test routing done");
  endtask
  task automatic t_global;
    restart(4'h0);
    glob(1'b0);
    periph_irq[19] <= 1'b1;
    tick(12);
    #1 chk("active", 32'h0, active_events);
    rdc("latched", `OFS_CORE_LATCHED, 32'h1000);
    glob(1'b1);
    tick(4);
    #1 chk("active", 32'h1000, active_events);
    rdc("global", `OFS_GLOBAL_CTRL, 32'h1);
    $display("test global enable done");
  endtask
  task automatic t_super;
    restart(4'h0);
    raise(3, 8, 7);
    supervisor_mode <= 1'b0;
    rdc("active user", `OFS_CORE_ACTIVE, 32'h0);
    wr(`OFS_CORE_ENABLE, 32'h0);
    supervisor_mode <= 1'b1;
    rdc("core enable", `OFS_CORE_ENABLE, 32'h0000ff80);
    wr(`OFS_CORE_ACTIVE, 32'h0);
    rdc("active", `OFS_CORE_ACTIVE, 32'h100);
    $display("test privilege done");
  endtask
  task automatic t_wake;
    restart(4'h0);
    wr(`OFS_PERIPH_WAKE, 32'h00100000);
    core_idle <= 1'b1;
    periph_irq[20] <= 1'b1;
    tick(5);
    #1 chk("wake", 32'h1, {31'h0, wake_req});
    @(posedge sys_clk);
    core_idle <= 1'b0;
    tick(2);
    #1 chk("wake", 32'h0, {31'h0, wake_req});
    $display("test wake done");
  endtask
  // Shared level with a slow pipeline, then a fresh edge while active
  task automatic t_nest;
    restart(4'h2);
    periph_irq <= 32'h00098000;
    tick(14);
    #1 chk("active", 32'h800, active_events);
    rdc("latched", `OFS_CORE_LATCHED, 32'h1000);
    periph_irq[15] <= 1'b0;
    tick(3);
    periph_irq[15] <= 1'b1;
    tick(10);
    rdc("latched", `OFS_CORE_LATCHED, 32'h1800);
    ret(4'hb);
    tick(10);
    #1 chk("active", 32'h800, active_events);
    ret(4'hb);
    tick(10);
    #1 chk("active", 32'h1000, active_events);
    $display("test shared level done");
  endtask

  task automatic tally_and_finish;
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    tick(16);
    rst <= 1'b0;
    t_reset;
    t_path;
    t_mask;
    t_periph;
    t_global;
    t_super;
    t_wake;
    t_nest;
    tally_and_finish;
  end
  // Watchdog, far beyond the roughly 290 cycles the tests need
  initial begin
    #200000;
    errors++;
    $display("mismatch watchdog expected done seen hang");
    tally_and_finish;
  end
endmodule // test_two_stage_interrupt_controller

bind two_stage_interrupt_controller irq_ctrl_assertions i_irq_ctrl_assertions (.sys_clk,
  .rst, .reg_addr, .reg_rd, .reg_rdata, .supervisor_mode, .periph_irq, .global_irq_off,
  .core_idle, .evt_accept, .evt_return, .evt_return_level, .svc_req, .svc_level,
  .active_events, .periph_status, .wake_req);
`default_nettype wire
